// ### design/duc_upconverter.sv
// Contract
// - one of three mixer modes: complex-real, complex-complex, real-real
// - operands: upstream samples plus oscillator cosine and sine
// - complex-to-real output is I times cosine minus Q times sine
// - complex-to-complex mode uses two mixer paths giving I and Q out
// - complex-to-complex mode accepts a negative oscillator frequency word
// - at half rate cosine alternates minus and plus one, sine stays zero
// - oscillator cosine and sine share one frequency
// - in the two complex modes output frequency equals word times clock over two to thirty-two
`default_nettype none
module duc_upconverter (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // configuration
    input wire duc_pkg::duc_mode_type i_mode,
    input wire logic [duc_pkg::FREQ_W-1:0] i_freq_word,
    // sample input
    input wire duc_pkg::duc_pair_type i_sample,
    input wire logic i_valid,
    // oscillator observation
    output duc_pkg::duc_osc_type o_osc,
    // mixer output
    output duc_pkg::duc_pair_type o_sample,
    output logic o_valid
);
    logic [duc_pkg::FREQ_W-1:0] phase;
    logic [duc_pkg::FREQ_W-1:0] next_phase;
    logic [duc_pkg::LUT_AW-1:0] addr_cos;
    logic [duc_pkg::LUT_AW-1:0] addr_sin;
    logic signed [duc_pkg::COEF_W-1:0] lut_cos;
    logic signed [duc_pkg::COEF_W-1:0] lut_sin;
    logic alt_sign;
    logic next_alt_sign;
    duc_pkg::duc_mode_type mode_d;
    duc_pkg::duc_pair_type samp_d;
    logic valid_d;
    duc_pkg::duc_osc_type osc;
    duc_pkg::duc_pair_type out;
    duc_pkg::duc_pair_type next_out;
    logic next_valid;
    logic signed [duc_pkg::PROD_W-1:0] p_ic;
    logic signed [duc_pkg::PROD_W-1:0] p_qs;
    logic signed [duc_pkg::PROD_W-1:0] p_is;
    logic signed [duc_pkg::PROD_W-1:0] p_qc;
    logic signed [duc_pkg::PROD_W:0] sum_i;
    logic signed [duc_pkg::PROD_W:0] sum_q;

    // lane limits for clipping the scaled mixer sums
    localparam logic signed [duc_pkg::SAMPLE_W-1:0] LANE_MAX =
        {1'h0, {(duc_pkg::SAMPLE_W-1){1'h1}}};
    localparam logic signed [duc_pkg::SAMPLE_W-1:0] LANE_MIN =
        {1'h1, {(duc_pkg::SAMPLE_W-1){1'h0}}};

    // scale by the coefficient weight and clip: a full-scale pair at an
    // oblique phase would otherwise wrap the lane
    function automatic logic signed [duc_pkg::SAMPLE_W-1:0] sat_lane(
        input logic signed [duc_pkg::PROD_W:0] sum
    );
        logic signed [duc_pkg::PROD_W:0] scaled;
        scaled = sum >>> (duc_pkg::COEF_W - 1);
        if (scaled > (duc_pkg::PROD_W+1)'(LANE_MAX)) begin
            sat_lane = LANE_MAX;
        end else if (scaled < (duc_pkg::PROD_W+1)'(LANE_MIN)) begin
            sat_lane = LANE_MIN;
        end else begin
            sat_lane = scaled[duc_pkg::SAMPLE_W-1:0];
        end
    endfunction : sat_lane

    // negative word is two's complement, wrap handles it
    always_comb begin
        next_phase = phase + i_freq_word;
        next_alt_sign = ~alt_sign;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            phase <= duc_pkg::PHASE_RESET;
            alt_sign <= 1'b0;
        end else begin
            phase <= next_phase;
            alt_sign <= next_alt_sign;
        end
    end

    // sine is cosine delayed a quarter turn, same frequency
    assign addr_cos = phase[duc_pkg::FREQ_W-1 -: duc_pkg::LUT_AW];
    assign addr_sin = addr_cos - duc_pkg::LUT_QUARTER;

    duc_lut u_lut (
        .i_clk(i_clk),
        .i_addr_a(addr_cos),
        .i_addr_b(addr_sin),
        .o_data_a(lut_cos),
        .o_data_b(lut_sin)
    );

    // align samples and mode with the lookup latency
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            mode_d <= duc_pkg::MODE_CPLX_REAL;
            samp_d <= '0;
            valid_d <= 1'b0;
        end else begin
            mode_d <= i_mode;
            samp_d <= i_sample;
            valid_d <= i_valid;
        end
    end

    // half-rate carrier: exact alternating unity, sine zero
    // real-real mode ignores the frequency word and forces half rate
    always_comb begin
        if (mode_d == duc_pkg::MODE_REAL_REAL) begin
            osc.cos_v = alt_sign ? duc_pkg::COEF_ONE : duc_pkg::COEF_MONE;
            osc.sin_v = '0;
        end else begin
            osc.cos_v = lut_cos;
            osc.sin_v = lut_sin;
        end
    end

    // operands: upstream samples and oscillator pair
    assign p_ic = samp_d.i * osc.cos_v;
    assign p_qs = samp_d.q * osc.sin_v;
    assign p_is = samp_d.i * osc.sin_v;
    assign p_qc = samp_d.q * osc.cos_v;

    always_comb begin
        sum_i = '0;
        sum_q = '0;
        unique case (mode_d)
            // single real output on the I lane, Q lane held zero
            duc_pkg::MODE_CPLX_REAL: begin
                sum_i = (duc_pkg::PROD_W+1)'(p_ic)
                    - (duc_pkg::PROD_W+1)'(p_qs);
                sum_q = '0;
            end
            // two mixer paths form complex output
            duc_pkg::MODE_CPLX_CPLX: begin
                sum_i = (duc_pkg::PROD_W+1)'(p_ic)
                    - (duc_pkg::PROD_W+1)'(p_qs);
                sum_q = (duc_pkg::PROD_W+1)'(p_is)
                    + (duc_pkg::PROD_W+1)'(p_qc);
            end
            // each real channel times alternating sign
            duc_pkg::MODE_REAL_REAL: begin
                sum_i = (duc_pkg::PROD_W+1)'(p_ic);
                sum_q = (duc_pkg::PROD_W+1)'(p_qc);
            end
            default: begin
                sum_i = '0;
                sum_q = '0;
            end
        endcase
        next_out.i = sat_lane(sum_i);
        next_out.q = sat_lane(sum_q);
        next_valid = valid_d;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            out <= '0;
            o_valid <= 1'b0;
            o_osc <= '0;
        end else begin
            out <= next_out;
            o_valid <= next_valid;
            o_osc <= osc;
        end
    end

    assign o_sample = out;

    // accumulator advances by the word every cycle
    a_phase_step: assert property (
        @(posedge i_clk) disable iff (i_reset)
        !$past(i_reset) |-> phase == $past(phase) + $past(i_freq_word))
        else $error("phase did not advance by frequency word");

    // sine is zero in real-real mode
    a_half_sin_zero: assert property (
        @(posedge i_clk) disable iff (i_reset)
        mode_d == duc_pkg::MODE_REAL_REAL |=> o_osc.sin_v == '0)
        else $error("sine not zero at half rate");

    // cosine alternates sign across two real-real cycles
    a_half_cos_alt: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (mode_d == duc_pkg::MODE_REAL_REAL)[*2] |->
        osc.cos_v == -$past(osc.cos_v))
        else $error("cosine did not alternate");

    a_real_q_zero: assert property (
        @(posedge i_clk) disable iff (i_reset)
        mode_d == duc_pkg::MODE_CPLX_REAL |=> o_sample.q == '0)
        else $error("complex-real Q lane not zero");

    // valid follows input by two cycles
    a_valid_lat: assert property (
        @(posedge i_clk) disable iff (i_reset)
        i_valid ##1 !i_reset |=> o_valid)
        else $error("valid latency wrong");

    // quarter-turn phase gives one zero and one full-scale lane
    a_quad_pair: assert property (
        @(posedge i_clk) disable iff (i_reset)
        (addr_cos & (duc_pkg::LUT_QUARTER - 8'h01)) == '0 |=>
        (lut_cos == '0) != (lut_sin == '0))
        else $error("cosine and sine not in quadrature");

    // at phase zero the Q path carries Q times unity
    a_cplx_q: assert property (
        @(posedge i_clk) disable iff (i_reset)
        mode_d == duc_pkg::MODE_CPLX_CPLX && osc.sin_v == '0 &&
        osc.cos_v == duc_pkg::COEF_ONE && samp_d.q != LANE_MIN |=>
        o_sample.q == $past(samp_d.q) - $past(samp_d.q > 0))
        else $error("complex Q lane mismatch");

    // output lanes zero with zero input in every mode
    a_zero_in: assert property (
        @(posedge i_clk) disable iff (i_reset)
        samp_d == '0 |=> o_sample == '0)
        else $error("output nonzero for zero input");
endmodule : duc_upconverter
`default_nettype wire

// ### design/duc_pkg.sv
`default_nettype none
package duc_pkg;
    localparam int SAMPLE_W = 16;
    localparam int COEF_W = 16;
    localparam int FREQ_W = 32;
    localparam int LUT_AW = 8;
    localparam int LUT_DEPTH = 256;
    localparam int PROD_W = SAMPLE_W + COEF_W;
    // unity of the signed coefficient lookup
    localparam logic signed [COEF_W-1:0] COEF_ONE = 16'sh7FFF;
    localparam logic signed [COEF_W-1:0] COEF_MONE = -16'sh7FFF;
    localparam logic [FREQ_W-1:0] FREQ_RESET = 32'h0000_0000;
    localparam logic [FREQ_W-1:0] PHASE_RESET = 32'h0000_0000;
    localparam logic [LUT_AW-1:0] LUT_QUARTER = 8'h40;

    typedef enum logic [1:0] {
        MODE_CPLX_REAL = 2'b00,
        MODE_CPLX_CPLX = 2'b01,
        MODE_REAL_REAL = 2'b10
    } duc_mode_type;

    typedef struct packed {
        logic signed [SAMPLE_W-1:0] i;
        logic signed [SAMPLE_W-1:0] q;
    } duc_pair_type;

    typedef struct packed {
        logic signed [COEF_W-1:0] cos_v;
        logic signed [COEF_W-1:0] sin_v;
    } duc_osc_type;
endpackage : duc_pkg
`default_nettype wire

// ### design/duc_lut.sv
`default_nettype none
// cosine lookup, registered read; sine read as cosine a quarter turn earlier
module duc_lut (
    // clock
    input wire logic i_clk,
    // read addresses
    input wire logic [duc_pkg::LUT_AW-1:0] i_addr_a,
    input wire logic [duc_pkg::LUT_AW-1:0] i_addr_b,
    // read data
    output logic signed [duc_pkg::COEF_W-1:0] o_data_a,
    output logic signed [duc_pkg::COEF_W-1:0] o_data_b
);
    logic signed [duc_pkg::COEF_W-1:0] table_mem [duc_pkg::LUT_DEPTH];

    // constant table built at elaboration, no file read
    // full-precision pi keeps the half-turn entry at exact negative unity
    initial begin
        for (int k = 0; k < duc_pkg::LUT_DEPTH; k++) begin
            table_mem[k] = duc_pkg::COEF_W'($rtoi(
                real'(duc_pkg::COEF_ONE) * $cos(2.0 * $acos(-1.0)
                * real'(k) / real'(duc_pkg::LUT_DEPTH))));
        end
    end

    always_ff @(posedge i_clk) begin
        o_data_a <= table_mem[i_addr_a];
        o_data_b <= table_mem[i_addr_b];
    end
endmodule : duc_lut
`default_nettype wire

// ### sim/duc_src_model.sv
`default_nettype none
// upstream sample source: one complex value per cycle while running
module duc_src_model (
    // clock
    input wire logic i_clk,
    // control
    input wire logic i_run,
    input wire duc_pkg::duc_pair_type i_value,
    // stream toward the mixer
    output duc_pkg::duc_pair_type o_sample,
    output logic o_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    duc_pkg::duc_pair_type last = '0;
    // idle data toggles so a stale value can never look right
    assign o_sample = i_run ? i_value : ~last;
    assign o_valid = i_run;
    always @(posedge i_clk) begin
        last <= o_sample;
    end
endmodule : duc_src_model
`default_nettype wire

// ### sim/duc_upconverter_tb.sv
`default_nettype none
module duc_upconverter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        duc_pkg::duc_mode_type mode;
        logic [31:0] word;
        logic [31:0] osc;
        logic [31:0] out;
    } duc_row_type;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    duc_pkg::duc_mode_type i_mode = duc_pkg::MODE_CPLX_REAL;
    logic [duc_pkg::FREQ_W-1:0] i_freq_word = 32'h0000_0000;
    logic run = 1'b0;
    duc_pkg::duc_pair_type value = 32'h4000_E000;
    duc_pkg::duc_pair_type i_sample;
    logic i_valid;
    duc_pkg::duc_osc_type o_osc;
    duc_pkg::duc_pair_type o_sample;
    logic o_valid;
    logic [31:0] first;
    int error_cnt = 0;
    int check_count = 0;
    int cycles = 0;
    duc_row_type rows [6];

    duc_src_model src_u (.i_clk(i_clk), .i_run(run), .i_value(value),
        .o_sample(i_sample), .o_valid(i_valid));
    duc_upconverter dut_u (.i_clk(i_clk), .i_reset(i_reset),
        .i_mode(i_mode), .i_freq_word(i_freq_word), .i_sample(i_sample),
        .i_valid(i_valid), .o_osc(o_osc), .o_sample(o_sample),
        .o_valid(o_valid));

    always #5 i_clk = ~i_clk;

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 500) begin
            error_cnt++;
            wrap_up();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // reset three cycles, then stream from phase zero
    task automatic start(input duc_pkg::duc_mode_type m, input logic [31:0] w);
        @(posedge i_clk);
        i_reset <= 1'b1;
        run <= 1'b0;
        i_mode <= m;
        i_freq_word <= w;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        run <= 1'b1;
    endtask : start

    initial begin
        rows = '{
            '{duc_pkg::MODE_CPLX_REAL, 32'h4000_0000, 32'h0000_7FFF,
              32'h1FFF_0000},
            '{duc_pkg::MODE_CPLX_CPLX, 32'h4000_0000, 32'h0000_7FFF,
              32'h1FFF_3FFF},
            '{duc_pkg::MODE_CPLX_CPLX, 32'hC000_0000, 32'h0000_8001,
              32'hE000_C000},
            '{duc_pkg::MODE_REAL_REAL, 32'h8000_0000, 32'h8001_0000,
              32'hC000_1FFF},
            '{duc_pkg::MODE_CPLX_REAL, 32'h0000_0000, 32'h7FFF_0000,
              32'h3FFF_0000},
            '{duc_pkg::MODE_CPLX_REAL, 32'hC000_0000, 32'h0000_8001,
              32'hE000_0000}};
        foreach (rows[n]) begin
            start(rows[n].mode, rows[n].word);
            first = 32'h3FFF_E000;
            if (rows[n].mode == duc_pkg::MODE_CPLX_REAL) begin
                first = 32'h3FFF_0000;
            end
            @(posedge i_clk);
            #1;
            check(32'(o_valid), 32'h0000_0000); // no early output
            check(o_sample, 32'h0000_0000); // flushed after reset
            @(posedge i_clk);
            #1;
            check(32'(o_valid), 32'h0000_0001); // first sample out
            check(o_sample, first); // phase zero
            check(o_osc, 32'h7FFF_0000); // phase zero carrier
            @(posedge i_clk);
            #1;
            check(o_sample, rows[n].out); // mixed
            check(o_osc, rows[n].osc); // phase step
        end
        start(duc_pkg::MODE_REAL_REAL, 32'h8000_0000);
        repeat (3) @(posedge i_clk);
        for (int k = 0; k < 4; k++) begin
            #1;
            check(o_osc, k[0] ? 32'h7FFF_0000 : 32'h8001_0000);
            @(posedge i_clk);
        end
        run <= 1'b0;
        @(posedge i_clk);
        run <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            @(posedge i_clk);
            #1;
            check(32'(o_valid), k == 0 ? 32'h0 : 32'h1); // gap kept
        end
        // second reset in mid-stream clears all three outputs
        @(posedge i_clk);
        i_reset <= 1'b1;
        @(posedge i_clk);
        #1;
        check(o_sample, 32'h0000_0000); // outputs cleared
        check(o_osc, 32'h0000_0000); // oscillator cleared
        check(32'(o_valid), 32'h0000_0000); // valid cleared
        wrap_up();
    end
endmodule : duc_upconverter_tb
`default_nettype wire
